//--- rtl/timer_pkg.sv
`default_nettype none
package timer_pkg;

  // Register word indices (word index = byte address / 4)
  localparam logic [2:0] ctrl_index = 3'h0;
  localparam logic [2:0] prescaler_index = 3'h1;
  localparam logic [2:0] timer_index = 3'h2;
  localparam logic [2:0] capture_index = 3'h3;
  localparam logic [2:0] status_index = 3'h4;
  localparam logic [2:0] mask_index = 3'h5;

  // timer_control field positions
  localparam int start_pos = 0;
  localparam int stop_pos = 1;
  localparam int polarity_pos = 2;
  localparam int out_enable_pos = 3;
  localparam int mode_lsb = 4;
  localparam int source_lsb = 8;

  // Status and mask bit positions
  localparam int underflow_pos = 0;
  localparam int measure_pos = 1;

  // Reset values and the last divider count for f8
  localparam logic [7:0] prescaler_reset = 8'hff;
  localparam logic [7:0] timer_reset = 8'hff;
  localparam logic [1:0] status_reset = 2'h0;
  localparam logic [1:0] mask_reset = 2'h0;
  localparam logic [2:0] f8_last = 3'h7;

  typedef enum logic [2:0] {
    mode_timer = 3'h0,
    mode_pulse_out = 3'h1,
    mode_event = 3'h2,
    mode_width = 3'h3,
    mode_period = 3'h4
  } mode_t;

  typedef enum logic [2:0] {
    src_f1 = 3'h0,
    src_f2 = 3'h1,
    src_f8 = 3'h2,
    src_onchip_osc = 3'h3,
    src_subclock = 3'h4
  } source_t;

  typedef struct packed {
    source_t source;
    mode_t mode;
    logic out_enable;
    logic polarity;
    logic start;
  } ctrl_t;

  localparam ctrl_t ctrl_reset = '{source: src_f1, mode: mode_timer, out_enable: 1'b0,
                                   polarity: 1'b0, start: 1'b0};

endpackage

`default_nettype wire

//--- rtl/prescaled_reload_down_timer.sv
// Contract
// - Eight-bit timer counts underflows of an eight-bit prescaler.
// - Prescaler and timer each hold a reload register and a counter.
// - Each stage's reload register and counter share one address.
// - Selected count source times all counting and reloading of both stages; event mode counts pin edges, period mode reloads timer on active edge.
// - Timer shares no state with other timers.
// - Timer mode counts the internal source only.
// - Pulse output mode toggles the pulse pin on each timer underflow.
// - Event counter mode counts external input pin pulses.
// - Pulse width mode counts internal source while input pulse is active.
// - Pulse period mode measures edge-to-edge interval with internal source.
// - Reduced variants cannot select the subclock source.
// - Both stages count down and reload on underflow, then continue.
// - Division ratio is one over (prescaler+1)(timer+1).
// - Start bit starts, clearing stops, forced-stop bit halts.
// - Interrupt request raised on every unmasked timer underflow.
`timescale 1ns/100ps
`default_nettype none

module prescaled_reload_down_timer #(
  parameter bit subclock_present = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic onchip_osc_clock,
  input wire logic subclock_div32,
  input wire logic pulse_io_in,
  output logic pulse_io_out,
  output logic pulse_io_oe_n,
  output logic pulse_out_pin,
  output logic irq
);

  // Word index; bits [1:0] are byte offset within the word
  function automatic logic [2:0] word_index(input logic [4:0] addr);
    return addr[4:2];
  endfunction

  // Input level after polarity; 1 means active
  function automatic logic active_level(input logic lvl, input logic pol);
    return lvl ^ pol;
  endfunction

  timer_pkg::ctrl_t ctrl;
  logic [7:0] prescaler_reload;
  logic [7:0] prescaler_count;
  logic [7:0] timer_reload;
  logic [7:0] timer_count;
  logic [7:0] capture;
  logic prescaler_pending;
  logic timer_pending;
  logic [1:0] status;
  logic [1:0] mask;
  logic [1:0] next_status;
  logic [1:0] events;
  logic [2:0] div;
  logic [2:0] osc_sync;
  logic [2:0] sub_sync;
  logic [2:0] io_sync;
  logic osc_level;
  logic sub_level;
  logic io_level;
  logic osc_prev;
  logic sub_prev;
  logic io_prev;
  logic osc_rise;
  logic sub_rise;
  logic io_active;
  logic io_active_edge;
  logic io_inactive_edge;
  logic source_pulse;
  logic tick;
  logic prescaler_underflow;
  logic timer_underflow;
  logic wr_ctrl;
  logic wr_prescaler;
  logic wr_timer;
  logic wr_status;
  logic wr_mask;
  logic forced_stop;
  logic mode_measures;

  // Bus access completes in the cycle waitrequest is low
  assign wr_ctrl = avs_write && !avs_waitrequest && word_index(avs_address) == timer_pkg::ctrl_index
                   && avs_byteenable[1:0] == 2'h3;
  assign wr_prescaler = avs_write && !avs_waitrequest
                        && word_index(avs_address) == timer_pkg::prescaler_index && avs_byteenable[0];
  assign wr_timer = avs_write && !avs_waitrequest
                    && word_index(avs_address) == timer_pkg::timer_index && avs_byteenable[0];
  assign wr_status = avs_write && !avs_waitrequest
                     && word_index(avs_address) == timer_pkg::status_index && avs_byteenable[0];
  assign wr_mask = avs_write && !avs_waitrequest
                   && word_index(avs_address) == timer_pkg::mask_index && avs_byteenable[0];
  assign forced_stop = wr_ctrl && avs_writedata[timer_pkg::stop_pos];

  // Three-stage synchronisers for pins from foreign clocks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_sync <= 3'h0;
      sub_sync <= 3'h0;
      io_sync <= 3'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], onchip_osc_clock};
      sub_sync <= {sub_sync[1:0], subclock_div32};
      io_sync <= {io_sync[1:0], pulse_io_in};
    end
  end

  // Level accepted only when second and third stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_level <= 1'b0;
      sub_level <= 1'b0;
      io_level <= 1'b0;
      osc_prev <= 1'b0;
      sub_prev <= 1'b0;
      io_prev <= 1'b0;
    end else begin
      if (osc_sync[1] == osc_sync[2]) osc_level <= osc_sync[2];
      if (sub_sync[1] == sub_sync[2]) sub_level <= sub_sync[2];
      if (io_sync[1] == io_sync[2]) io_level <= io_sync[2];
      osc_prev <= osc_level;
      sub_prev <= sub_level;
      io_prev <= io_level;
    end
  end

  assign osc_rise = osc_level && !osc_prev;
  assign sub_rise = sub_level && !sub_prev;
  assign io_active = active_level(io_level, ctrl.polarity);
  assign io_active_edge = io_active && !active_level(io_prev, ctrl.polarity);
  assign io_inactive_edge = !io_active && active_level(io_prev, ctrl.polarity);
  assign mode_measures = ctrl.mode == timer_pkg::mode_width || ctrl.mode == timer_pkg::mode_period;

  // Free divider for f2 and f8
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div <= 3'h0;
    end else begin
      div <= div + 3'h1;
    end
  end

  always_comb begin
    case (ctrl.source)
      timer_pkg::src_f1: source_pulse = 1'b1;
      timer_pkg::src_f2: source_pulse = div[0];
      timer_pkg::src_f8: source_pulse = div == timer_pkg::f8_last;
      timer_pkg::src_onchip_osc: source_pulse = osc_rise;
      timer_pkg::src_subclock: source_pulse = sub_rise;
      default: source_pulse = 1'b0;
    endcase
  end

  // Count tick per mode; one tick drives both stages
  always_comb begin
    case (ctrl.mode)
      timer_pkg::mode_timer: tick = source_pulse;
      timer_pkg::mode_pulse_out: tick = source_pulse;
      timer_pkg::mode_event: tick = io_active_edge;
      timer_pkg::mode_width: tick = source_pulse && io_active;
      timer_pkg::mode_period: tick = source_pulse;
      default: tick = 1'b0;
    endcase
    tick = tick && ctrl.start;
  end

  assign prescaler_underflow = tick && prescaler_count == 8'h00;
  assign timer_underflow = prescaler_underflow && timer_count == 8'h00;

  // Control register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= timer_pkg::ctrl_reset;
    end else if (wr_ctrl) begin
      ctrl.start <= avs_writedata[timer_pkg::start_pos] && !avs_writedata[timer_pkg::stop_pos];
      ctrl.polarity <= avs_writedata[timer_pkg::polarity_pos];
      ctrl.out_enable <= avs_writedata[timer_pkg::out_enable_pos];
      if (avs_writedata[timer_pkg::mode_lsb +: 3] <= timer_pkg::mode_period) begin
        ctrl.mode <= timer_pkg::mode_t'(avs_writedata[timer_pkg::mode_lsb +: 3]);
      end
      // Subclock missing on reduced parts: select is refused
      if (avs_writedata[timer_pkg::source_lsb +: 3] < timer_pkg::src_subclock
          || (subclock_present && avs_writedata[timer_pkg::source_lsb +: 3] == timer_pkg::src_subclock)) begin
        ctrl.source <= timer_pkg::source_t'(avs_writedata[timer_pkg::source_lsb +: 3]);
      end
    end
  end

  // Prescaler stage: own reload register and counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescaler_reload <= timer_pkg::prescaler_reset;
      prescaler_count <= timer_pkg::prescaler_reset;
      prescaler_pending <= 1'b0;
    end else begin
      if (wr_prescaler) prescaler_reload <= avs_writedata[7:0];
      if (forced_stop) begin
        prescaler_count <= prescaler_reload;
        prescaler_pending <= 1'b0;
      end else if (wr_prescaler && !ctrl.start) begin
        prescaler_count <= avs_writedata[7:0];
        prescaler_pending <= 1'b0;
      end else if (tick) begin
        // Pending value lands on the next count-source tick
        if (prescaler_underflow || prescaler_pending) prescaler_count <= prescaler_reload;
        else prescaler_count <= prescaler_count - 8'h01;
        prescaler_pending <= wr_prescaler;
      end else if (wr_prescaler) begin
        prescaler_pending <= 1'b1;
      end
    end
  end

  // Timer stage: counts prescaler underflows
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_reload <= timer_pkg::timer_reset;
      timer_count <= timer_pkg::timer_reset;
      timer_pending <= 1'b0;
    end else begin
      if (wr_timer) timer_reload <= avs_writedata[7:0];
      if (forced_stop) begin
        timer_count <= timer_reload;
        timer_pending <= 1'b0;
      end else if (wr_timer && !ctrl.start) begin
        timer_count <= avs_writedata[7:0];
        timer_pending <= 1'b0;
      end else if (ctrl.mode == timer_pkg::mode_period && io_active_edge && ctrl.start) begin
        timer_count <= timer_reload;
        timer_pending <= 1'b0;
      end else if (prescaler_underflow) begin
        if (timer_underflow || timer_pending) timer_count <= timer_reload;
        else timer_count <= timer_count - 8'h01;
        timer_pending <= wr_timer;
      end else if (wr_timer) begin
        timer_pending <= 1'b1;
      end
    end
  end

  // Measurement capture: width at pulse end, period at each active edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capture <= 8'h00;
    end else if (ctrl.start && ((ctrl.mode == timer_pkg::mode_width && io_inactive_edge)
                 || (ctrl.mode == timer_pkg::mode_period && io_active_edge))) begin
      capture <= timer_count;
    end
  end

  // Pulse pins; io pin is driven only in pulse output mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse_io_out <= 1'b0;
      pulse_io_oe_n <= 1'b1;
      pulse_out_pin <= 1'b0;
    end else begin
      pulse_io_oe_n <= ctrl.mode != timer_pkg::mode_pulse_out;
      if (ctrl.mode == timer_pkg::mode_pulse_out && timer_underflow) begin
        pulse_io_out <= !pulse_io_out;
        pulse_out_pin <= ctrl.out_enable && pulse_io_out;
      end else begin
        pulse_out_pin <= ctrl.out_enable && !pulse_io_out;
      end
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  assign events[timer_pkg::underflow_pos] = timer_underflow;
  assign events[timer_pkg::measure_pos] = ctrl.start && mode_measures
    && ((ctrl.mode == timer_pkg::mode_width) ? io_inactive_edge : io_active_edge);

  always_comb begin
    next_status = status;
    if (wr_status) next_status = status & ~avs_writedata[1:0];
    next_status = next_status | events;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= timer_pkg::status_reset;
      mask <= timer_pkg::mask_reset;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (wr_mask) mask <= avs_writedata[1:0];
      irq <= |(next_status & (wr_mask ? avs_writedata[1:0] : mask));
    end
  end

  // One wait cycle per access; unmapped reads return zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (word_index(avs_address))
          timer_pkg::ctrl_index: avs_readdata <= {21'h0, ctrl.source, 1'b0, ctrl.mode,
                                                  ctrl.out_enable, ctrl.polarity, 1'b0, ctrl.start};
          timer_pkg::prescaler_index: avs_readdata <= {24'h0, prescaler_count};
          timer_pkg::timer_index: avs_readdata <= {24'h0, timer_count};
          timer_pkg::capture_index: avs_readdata <= {24'h0, capture};
          timer_pkg::status_index: avs_readdata <= {30'h0, status};
          timer_pkg::mask_index: avs_readdata <= {30'h0, mask};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

endmodule // prescaled_reload_down_timer

`default_nettype wire

//--- tb/timer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module timer_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pulse_io_out,
  input wire logic pulse_io_oe_n,
  input wire logic pulse_out_pin,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_answer;
    s_req |=> s_done;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not in one cycle");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_rd_hold;
    !$past(avs_read) |-> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped;
    avs_read && avs_waitrequest && avs_address[4:2] > 3'h5 |=> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_off;
    avs_write && !avs_waitrequest && avs_address[4:2] == 3'h5 && avs_byteenable[0]
      && avs_writedata[1:0] == 2'h0 |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq high with mask clear");
  property p_pin_quiet;
    pulse_io_oe_n && $past(pulse_io_oe_n) |-> $stable(pulse_io_out);
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("pulse pin moved undriven");
  property p_pin_inv;
    pulse_out_pin |-> !pulse_io_out || !$past(pulse_io_out);
  endproperty
  a_pin_inv: assert property (p_pin_inv) else $error("out pin not inverted");
endmodule // timer_chk
`default_nettype wire

//--- tb/pin_src.sv
`timescale 1ns/100ps
`default_nettype none
module pin_src (
  input wire logic core_clk,
  output logic osc,
  output logic sub,
  output logic pin
);
  initial begin
    osc = 1'b0;
    sub = 1'b0;
    pin = 1'b0;
  end
  // Oscillators run free, unrelated to frames
  always begin
    repeat (2) @(posedge core_clk);
    osc <= ~osc;
  end
  always begin
    repeat (32) @(posedge core_clk);
    sub <= ~sub;
  end
  // Pulses wide enough for the input synchroniser
  task burst(input int n);
    repeat (n) begin
      repeat (3) @(posedge core_clk);
      pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      pin <= 1'b0;
    end
  endtask
endmodule // pin_src
`default_nettype wire

//--- tb/prescaled_reload_down_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(s, e, v) begin checked++; if ((v) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", s, e, v); end end
module prescaled_reload_down_timer_bench;
  logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, osc, sub, pin, pulse_io_out, pulse_io_oe_n, pulse_out_pin, irq;
  int fails = 0, checked = 0, n;
  always #5 core_clk = ~core_clk;
  pin_src src (.core_clk(core_clk), .osc(osc), .sub(sub), .pin(pin));
  prescaled_reload_down_timer DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .onchip_osc_clock(osc), .subclock_div32(sub), .pulse_io_in(pin), .pulse_io_out(pulse_io_out),
    .pulse_io_oe_n(pulse_io_oe_n), .pulse_out_pin(pulse_out_pin), .irq(irq));
  task test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task acc(input logic [4:0] a, input logic [31:0] w, input logic wr);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= w;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wr(input logic [4:0] a, input logic [31:0] w);
    acc(a, w, 1'b1);
  endtask
  task rc(input logic [4:0] a, input logic [31:0] e, input string s);
    acc(a, 32'h0, 1'b0);
    `CHK(s, e, d)
  endtask
  // Counts edges up to the next toggle of the pulse pin
  task gap(output int k);
    logic v;
    v = pulse_io_out;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pulse_io_out === v && k < 100);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rc(5'h00, 32'h0, "ctrl reset");
    rc(5'h04, 32'hff, "pre reset");
    rc(5'h08, 32'hff, "tim reset");
    rc(5'h10, 32'h0, "stat reset");
    rc(5'h14, 32'h0, "mask reset");
    wr(5'h18, 32'h5a);
    rc(5'h18, 32'h0, "unmapped");
    wr(5'h04, 32'h1);
    wr(5'h08, 32'h2);
    rc(5'h08, 32'h2, "tim load");
    wr(5'h14, 32'h1);
    wr(5'h00, 32'h19);
    gap(n);
    gap(n);
    `CHK("period", 6, n)
    `CHK("oe_n", 1'b0, pulse_io_oe_n)
    `CHK("irq on", 1'b1, irq)
    rc(5'h10, 32'h1, "stat uf");
    wr(5'h00, 32'h1a);
    rc(5'h00, 32'h18, "stopped");
    rc(5'h08, 32'h2, "tim reload");
    rc(5'h04, 32'h1, "pre reload");
    `CHK("out pin", ~pulse_io_out, pulse_out_pin)
    wr(5'h14, 32'h0);
    repeat (3) @(posedge core_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(5'h10, 32'h1);
    rc(5'h10, 32'h0, "w1c");
    wr(5'h04, 32'h0);
    wr(5'h08, 32'h3);
    wr(5'h00, 32'h21);
    src.burst(3);
    repeat (8) @(posedge core_clk);
    rc(5'h08, 32'h0, "event count");
    rc(5'h10, 32'h0, "event early");
    src.burst(1);
    repeat (8) @(posedge core_clk);
    rc(5'h10, 32'h1, "event uf");
    rc(5'h08, 32'h3, "event reload");
    wr(5'h00, 32'h2);
    wr(5'h08, 32'hff);
    wr(5'h00, 32'h301);
    repeat (40) @(posedge core_clk);
    wr(5'h00, 32'h300);
    acc(5'h08, 32'h0, 1'b0);
    `CHK("osc count", 1'b1, d < 32'hff && d > 32'hf0)
    wr(5'h00, 32'h400);
    rc(5'h00, 32'h400, "subclock");
    wr(5'h00, 32'h570);
    rc(5'h00, 32'h400, "refused");
    wr(5'h00, 32'h2);
    wr(5'h10, 32'h3);
    wr(5'h00, 32'h31);
    src.burst(1);
    repeat (8) @(posedge core_clk);
    rc(5'h0c, 32'hfc, "width cap");
    rc(5'h10, 32'h2, "width done");
    wr(5'h10, 32'h2);
    wr(5'h00, 32'h41);
    src.burst(2);
    repeat (8) @(posedge core_clk);
    rc(5'h0c, 32'hfa, "period cap");
    rc(5'h10, 32'h2, "period done");
    wr(5'h00, 32'h2);
    wr(5'h04, 32'h1);
    wr(5'h08, 32'h1);
    wr(5'h00, 32'h111);
    gap(n);
    gap(n);
    `CHK("f2 period", 8, n)
    // Source switched while running: first two gaps may be ragged
    wr(5'h00, 32'h211);
    repeat (3) gap(n);
    `CHK("f8 period", 32, n)
    wr(5'h08, 32'h3);
    repeat (3) gap(n);
    `CHK("running write", 64, n)
    test_done();
  end
  // Whole run needs under two thousand cycles
  initial begin
    #50000;
    fails++;
    test_done();
  end
endmodule // prescaled_reload_down_timer_bench
bind prescaled_reload_down_timer timer_chk chk (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pulse_io_out, .pulse_io_oe_n,
  .pulse_out_pin, .irq);
`default_nettype wire
